// *** logic/thermal_overload_stage.sv ***
// thermal overload output stage: thresholds, trip delay, blocking and ahb-lite registers
`timescale 1ns/1ps
// Function
// - threshold levels are compared only against the thermal capacity value from the thermal image
// - alarm 1 asserts when enabled and capacity reaches its level, default 40 %
// - alarm 2 asserts when enabled at its own independent level, default 40 %
// - restart inhibit asserts when enabled at inhibit level, default 80 %
// - trip asserts when enabled at trip level 100 %; all enables reset off
// - active parameter set may be switched while running, applied at once
// - blocking input is sampled once at the start of each program cycle
// - pick-up without blocking raises start and runs the operate delay
// - pick-up with blocking raises blocked and nothing further is done
// - blocking during start clears start and releases like pick-up dropping
// - operating mode on, blocked, test, test-and-blocked or off
// - condition code reported; normal condition drives no alarm, inhibit or trip output
// - load classed light, normal, overloading or high overload from current
// - invalid service factor raises a fault and 1.0 is used instead
// - inconsistent ambient settings raise a fault and 1.0 is used instead
module thermal_overload_stage
  import thermal_overload_pkg::*;
#(
  parameter int STEP_CYC = DELAY_STEP_CYC
) (
  input  wire logic                                     hclk,
  input  wire logic                                     hresetn,
  input  wire logic                                     ce,
  input  wire logic                                     hsel,
  input  wire logic [31:0]                              haddr,
  input  wire logic [1:0]                               htrans,
  input  wire logic                                     hwrite,
  input  wire logic [2:0]                               hsize,
  input  wire logic [31:0]                              hwdata,
  input  wire logic                                     hready,
  output logic      [31:0]                              hrdata,
  output logic                                          hreadyout,
  output logic                                          hresp,
  input  wire logic                                     cycle_tick,
  input  wire logic [thermal_overload_pkg::TH_W-1:0]    theta,
  input  wire logic [thermal_overload_pkg::CUR_W-1:0]   i_meas,
  input  wire logic [thermal_overload_pkg::CUR_W-1:0]   i_pickup,
  input  wire logic [thermal_overload_pkg::K_W-1:0]     k_amb_calc,
  input  wire logic                                     block_in,
  output logic                                          alarm1,
  output logic                                          alarm2,
  output logic                                          inhibit,
  output logic                                          trip,
  output logic                                          start,
  output logic                                          blocked,
  output logic      [2:0]                               condition,
  output logic      [1:0]                               load_class,
  output logic                                          sf_fault,
  output logic                                          amb_fault,
  output logic      [thermal_overload_pkg::K_W-1:0]     service_factor_used,
  output logic      [thermal_overload_pkg::K_W-1:0]     k_amb_used,
  output logic                                          test_mode
);
  import thermal_overload_pkg::*;

  // register file
  logic [NLVL-1:0]  en_r, en_nxt;
  logic [2:0]       mode_r, mode_nxt;
  logic             sel_r, sel_nxt;
  logic [TH_W-1:0]  lvl_r [2][NLVL];
  logic [TH_W-1:0]  lvl_nxt [2][NLVL];
  logic [DLY_W-1:0] dly_r [2];
  logic [DLY_W-1:0] dly_nxt [2];
  logic [K_W-1:0]   sf_r, sf_nxt;
  logic [9:0]       tlo_r, tlo_nxt, thi_r, thi_nxt;
  logic [K_W-1:0]   klo_r, klo_nxt, khi_r, khi_nxt;
  logic             wpend_r, wpend_nxt;
  logic [7:0]       waddr_r, waddr_nxt;
  logic [31:0]      hrdata_nxt;
  logic [31:0]      status_w;
  logic             acc;
  logic [7:0]       a8, wa_set;
  logic             wsel;
  logic [1:0]       widx;

  // evaluation state
  logic             blk_s1_r, blk_s2_r;
  logic             blk_r, blk_nxt;
  seq_state_t       st_r, st_nxt;
  logic [$clog2(STEP_CYC+1)-1:0] pre_r, pre_nxt;
  logic [DLY_W-1:0] cnt_r, cnt_nxt;
  logic             a1_nxt, a2_nxt, inh_nxt, trip_nxt;
  logic [2:0]       cond_nxt;
  logic [1:0]       load_nxt;
  logic             blk_eff, off;
  logic [NLVL-1:0]  hit;

  assign acc       = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign a8        = haddr[7:0];
  assign hreadyout = ce;  // a frozen stage holds the bus rather than lose a write
  assign hresp     = 1'b0;
  assign wa_set    = waddr_r & SET_MASK;
  assign wsel      = (wa_set == A_SET1);
  assign widx      = waddr_r[3:2];

  assign status_w = {13'h0000, test_mode, amb_fault, sf_fault,
                     2'h0, load_class, 1'b0, condition,
                     2'h0, blocked, start, trip, inhibit, alarm2, alarm1};

  always_comb begin
    en_nxt    = en_r;
    mode_nxt  = mode_r;
    sel_nxt   = sel_r;
    lvl_nxt   = lvl_r;
    dly_nxt   = dly_r;
    sf_nxt    = sf_r;
    tlo_nxt   = tlo_r;
    thi_nxt   = thi_r;
    klo_nxt   = klo_r;
    khi_nxt   = khi_r;
    wpend_nxt = acc && hwrite;
    waddr_nxt = acc ? a8 : waddr_r;
    hrdata_nxt = hrdata;
    if (wpend_r) begin
      case (waddr_r)
        A_CTRL: begin
          en_nxt   = hwdata[CTRL_EN_LSB +: NLVL];
          mode_nxt = hwdata[CTRL_MODE_LSB +: 3];
          sel_nxt  = hwdata[CTRL_SEL_BIT];
        end
        A_SF:    sf_nxt = hwdata[K_W-1:0];
        A_AMB_T: begin
          tlo_nxt = hwdata[9:0];
          thi_nxt = hwdata[AMB_HI_LSB +: 10];
        end
        A_AMB_K: begin
          klo_nxt = hwdata[K_W-1:0];
          khi_nxt = hwdata[AMB_HI_LSB +: K_W];
        end
        default: begin
          if ((wa_set == A_SET0) || wsel) begin
            if (waddr_r[4]) dly_nxt[wsel] = hwdata[DLY_W-1:0];
            else lvl_nxt[wsel][widx] = hwdata[TH_W-1:0];
          end
        end
      endcase
    end
    if (acc && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;  // unmapped reads as zero
      case (a8)
        A_CTRL:   hrdata_nxt = {23'h000000, sel_r, 1'b0, mode_r, en_r};
        A_STATUS: hrdata_nxt = status_w;
        A_SF:     hrdata_nxt = {22'h000000, sf_r};
        A_AMB_T:  hrdata_nxt = {6'h00, thi_r, 6'h00, tlo_r};
        A_AMB_K:  hrdata_nxt = {6'h00, khi_r, 6'h00, klo_r};
        default: begin
          if (((a8 & SET_MASK) == A_SET0) || ((a8 & SET_MASK) == A_SET1)) begin
            if (a8[4]) hrdata_nxt = {12'h000, dly_r[(a8 & SET_MASK) == A_SET1]};
            else hrdata_nxt = {21'h000000, lvl_r[(a8 & SET_MASK) == A_SET1][a8[3:2]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r    <= '0;
      mode_r  <= MODE_ON;
      sel_r   <= 1'b0;
      for (int s = 0; s < 2; s++) begin
        lvl_r[s][0] <= LVL_A1_RST;
        lvl_r[s][1] <= LVL_A2_RST;
        lvl_r[s][2] <= LVL_INH_RST;
        lvl_r[s][3] <= LVL_TRIP_RST;
        dly_r[s]    <= '0;
      end
      sf_r    <= K_ONE;
      tlo_r   <= AMB_TLO_RST;
      thi_r   <= AMB_THI_RST;
      klo_r   <= K_ONE;
      khi_r   <= K_ONE;
      wpend_r <= 1'b0;
      waddr_r <= '0;
      hrdata  <= '0;
    end else if (ce) begin
      en_r    <= en_nxt;
      mode_r  <= mode_nxt;
      sel_r   <= sel_nxt;
      lvl_r   <= lvl_nxt;
      dly_r   <= dly_nxt;
      sf_r    <= sf_nxt;
      tlo_r   <= tlo_nxt;
      thi_r   <= thi_nxt;
      klo_r   <= klo_nxt;
      khi_r   <= khi_nxt;
      wpend_r <= wpend_nxt;
      waddr_r <= waddr_nxt;
      hrdata  <= hrdata_nxt;
    end
  end

  // blocking comes from another block's logic; synchronised before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
    end else if (ce) begin
      blk_s1_r <= block_in;
      blk_s2_r <= blk_s1_r;
    end
  end

  // the selected set is read live, so a set switch takes effect next cycle
  always_comb begin
    for (int k = 0; k < NLVL; k++) begin
      hit[k] = en_r[k] && (theta >= lvl_r[sel_r][k]);
    end
  end

  assign off     = (mode_r == MODE_OFF);
  // on a tick the fresh synchronised sample counts, otherwise the one held from the last tick
  assign blk_eff = (cycle_tick ? blk_s2_r : blk_r)
                   || (mode_r == MODE_BLOCKED) || (mode_r == MODE_TEST_BLK);

  always_comb begin
    blk_nxt   = cycle_tick ? blk_s2_r : blk_r;
    st_nxt    = st_r;
    a1_nxt    = alarm1;
    a2_nxt    = alarm2;
    inh_nxt   = inhibit;
    load_nxt  = load_class;
    pre_nxt   = pre_r;
    cnt_nxt   = cnt_r;
    if (cycle_tick) begin
      // decisions use this cycle's sample, not the stale one
      if (off || !hit[3]) st_nxt = ST_IDLE;
      else if (blk_eff)
        st_nxt = ST_BLOCKED;
      else st_nxt = ST_STARTED;
      a1_nxt  = hit[0] && !off;
      a2_nxt  = hit[1] && !off;
      inh_nxt = hit[2] && !off;
      if (i_meas < LIGHT_LIM) load_nxt = LOAD_LIGHT;
      else if (i_meas > HIGH_LIM) load_nxt = LOAD_HIGH;
      else if (i_meas > i_pickup) load_nxt = LOAD_OVER;
      else load_nxt = LOAD_NORMAL;
    end
    // operate delay runs only while started; leaving start releases it
    if (st_r == ST_STARTED && st_nxt == ST_STARTED) begin
      if (cnt_r < dly_r[sel_r]) begin
        if (pre_r == ($clog2(STEP_CYC+1))'(STEP_CYC - 1)) begin
          pre_nxt = '0;
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          pre_nxt = pre_r + 1'b1;
        end
      end
    end else begin
      pre_nxt = '0;
      cnt_nxt = '0;
    end
    // registered count, so every delay step adds exactly one full step of clocks
    trip_nxt = (st_nxt == ST_STARTED) && (st_r == ST_STARTED)
               && (cnt_r >= dly_r[sel_r]);
    if (st_nxt == ST_BLOCKED) cond_nxt = COND_BLOCKED;
    else if (trip_nxt) cond_nxt = COND_TRIP;
    else if (inh_nxt) cond_nxt = COND_INHIBIT;
    else if (a2_nxt) cond_nxt = COND_ALARM2;
    else if (a1_nxt) cond_nxt = COND_ALARM1;
    else cond_nxt = COND_NORMAL;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_r      <= 1'b0;
      st_r       <= ST_IDLE;
      pre_r      <= '0;
      cnt_r      <= '0;
      alarm1     <= 1'b0;
      alarm2     <= 1'b0;
      inhibit    <= 1'b0;
      trip       <= 1'b0;
      start      <= 1'b0;
      blocked    <= 1'b0;
      condition  <= COND_NORMAL;
      load_class <= LOAD_LIGHT;
    end else if (ce) begin
      blk_r      <= blk_nxt;
      st_r       <= st_nxt;
      pre_r      <= pre_nxt;
      cnt_r      <= cnt_nxt;
      alarm1     <= a1_nxt;
      alarm2     <= a2_nxt;
      inhibit    <= inh_nxt;
      trip       <= trip_nxt;
      start      <= (st_nxt == ST_STARTED);
      blocked    <= (st_nxt == ST_BLOCKED);
      condition  <= cond_nxt;
      load_class <= load_nxt;
    end
  end

  // setting supervision is continuous so a bad write is flagged at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sf_fault            <= 1'b0;
      amb_fault           <= 1'b0;
      service_factor_used <= K_ONE;
      k_amb_used          <= K_ONE;
      test_mode           <= 1'b0;
    end else if (ce) begin
      sf_fault  <= (sf_r < SF_MIN) || (sf_r > SF_MAX);
      service_factor_used <= ((sf_r < SF_MIN) || (sf_r > SF_MAX)) ? K_ONE : sf_r;
      amb_fault <= ($signed(tlo_r) >= $signed(thi_r)) || (klo_r == '0) || (khi_r == '0)
                   || (klo_r > K_MAX) || (khi_r > K_MAX);
      k_amb_used <= (($signed(tlo_r) >= $signed(thi_r)) || (klo_r == '0) || (khi_r == '0)
                   || (klo_r > K_MAX) || (khi_r > K_MAX)) ? K_ONE : k_amb_calc;
      test_mode <= (mode_r == MODE_TEST) || (mode_r == MODE_TEST_BLK);
    end
  end
endmodule

// *** logic/thermal_overload_pkg.sv ***
// constants, field layouts and types of the thermal overload output stage
package thermal_overload_pkg;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int DELAY_STEP_NS  = 5_000_000;
  localparam int DELAY_STEP_CYC = (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TH_W           = 11;
  localparam int DLY_W          = 20;
  localparam int K_W            = 10;
  localparam int CUR_W          = 16;
  localparam int NLVL           = 4;
  // register byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_SF      = 8'h08;
  localparam logic [7:0] A_AMB_T   = 8'h0C;
  localparam logic [7:0] A_AMB_K   = 8'h10;
  localparam logic [7:0] A_SET0    = 8'h20;
  localparam logic [7:0] A_SET1    = 8'h40;
  localparam logic [7:0] SET_MASK  = 8'hE0;
  localparam logic [7:0] A_DLY_OFS = 8'h10;
  // control fields
  localparam int CTRL_EN_LSB   = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_SEL_BIT  = 8;
  localparam int AMB_HI_LSB    = 16;
  // status fields
  localparam int ST_OUT_LSB  = 0;
  localparam int ST_START    = 4;
  localparam int ST_BLK      = 5;
  localparam int ST_COND_LSB = 8;
  localparam int ST_LOAD_LSB = 12;
  localparam int ST_SF_FLT   = 16;
  localparam int ST_AMB_FLT  = 17;
  localparam int ST_TEST     = 18;
  // reset values, levels in 0.1 % of thermal capacity
  localparam logic [TH_W-1:0] LVL_A1_RST   = 11'h190;
  localparam logic [TH_W-1:0] LVL_A2_RST   = 11'h190;
  localparam logic [TH_W-1:0] LVL_INH_RST  = 11'h320;
  localparam logic [TH_W-1:0] LVL_TRIP_RST = 11'h3E8;
  localparam logic [K_W-1:0]  K_ONE        = 10'h064;
  localparam logic [K_W-1:0]  K_MAX        = 10'h1F4;
  localparam logic [K_W-1:0]  SF_MIN       = 10'h064;
  localparam logic [K_W-1:0]  SF_MAX       = 10'h1F4;
  localparam logic [9:0]      AMB_TLO_RST  = 10'h000;
  localparam logic [9:0]      AMB_THI_RST  = 10'h02D;
  // current in 0.001 x nominal
  localparam logic [CUR_W-1:0] LIGHT_LIM = 16'h000A;
  localparam logic [CUR_W-1:0] HIGH_LIM  = 16'h07D0;
  // operating mode encodings
  localparam logic [2:0] MODE_ON       = 3'h0;
  localparam logic [2:0] MODE_BLOCKED  = 3'h1;
  localparam logic [2:0] MODE_TEST     = 3'h2;
  localparam logic [2:0] MODE_TEST_BLK = 3'h3;
  localparam logic [2:0] MODE_OFF      = 3'h4;
  // condition codes
  localparam logic [2:0] COND_NORMAL  = 3'h0;
  localparam logic [2:0] COND_ALARM1  = 3'h1;
  localparam logic [2:0] COND_ALARM2  = 3'h2;
  localparam logic [2:0] COND_INHIBIT = 3'h3;
  localparam logic [2:0] COND_TRIP    = 3'h4;
  localparam logic [2:0] COND_BLOCKED = 3'h5;
  // load classes
  localparam logic [1:0] LOAD_LIGHT  = 2'h0;
  localparam logic [1:0] LOAD_NORMAL = 2'h1;
  localparam logic [1:0] LOAD_OVER   = 2'h2;
  localparam logic [1:0] LOAD_HIGH   = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_STARTED = 3'b010,
    ST_BLOCKED = 3'b100
  } seq_state_t;
endpackage

// *** tb/block_source.sv ***
// behavioural blocking source standing in for the blocking matrix
`timescale 1ns/1ps
module block_source (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       blk_req,
  input  wire logic [3:0] lag,
  output logic            block_in
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       blk_nxt;
  // a lag of zero answers at once, a larger lag models a slow matrix
  always_comb begin
    cnt_nxt = 4'h0;
    blk_nxt = block_in;
    if (blk_req != block_in) begin
      if (cnt_r >= lag) begin
        blk_nxt = blk_req;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r    <= 4'h0;
      block_in <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      block_in <= blk_nxt;
    end
  end
endmodule

// *** tb/thermal_overload_stage_asserts.sv ***
// port checker for the thermal overload output stage
`timescale 1ns/1ps
module thermal_overload_stage_chk
  import thermal_overload_pkg::*;
(
  input wire logic                                hclk,
  input wire logic                                hresetn,
  input wire logic                                ce,
  input wire logic                                hreadyout,
  input wire logic                                hresp,
  input wire logic                                cycle_tick,
  input wire logic                                alarm1,
  input wire logic                                alarm2,
  input wire logic                                inhibit,
  input wire logic                                trip,
  input wire logic                                start,
  input wire logic                                blocked,
  input wire logic [2:0]                          condition,
  input wire logic                                sf_fault,
  input wire logic                                amb_fault,
  input wire logic [thermal_overload_pkg::K_W-1:0] service_factor_used,
  input wire logic [thermal_overload_pkg::K_W-1:0] k_amb_used
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_tracks_ce: assert property (hreadyout == ce && !hresp)
    else $error("ready or response wrong");
  a_trip_in_start: assert property (trip |-> start)
    else $error("trip without start");
  a_trip_after_start: assert property ($rose(trip) |-> $past(start) && start)
    else $error("trip rose before start");
  a_normal_quiet: assert property (condition == COND_NORMAL |-> !(alarm1 | alarm2 | inhibit | trip))
    else $error("outputs driven in normal");
  a_blocked_stops: assert property (blocked |-> !start && !trip && condition == COND_BLOCKED)
    else $error("blocked yet started");
  a_sf_override: assert property (sf_fault |-> service_factor_used == K_ONE)
    else $error("service factor not overridden");
  a_amb_override: assert property (amb_fault |-> k_amb_used == K_ONE)
    else $error("ambient k not overridden");
  a_rise_on_tick: assert property (($rose(alarm1) || $rose(alarm2) || $rose(inhibit) || $rose(start))
    |-> $past(cycle_tick)) else $error("output rose off the tick");
  a_trip_condition: assert property (trip |-> condition == COND_TRIP)
    else $error("trip without trip condition");
endmodule
bind thermal_overload_stage thermal_overload_stage_chk chk_u (.hclk, .hresetn, .ce, .hreadyout,
  .hresp, .cycle_tick, .alarm1, .alarm2, .inhibit, .trip, .start, .blocked, .condition,
  .sf_fault, .amb_fault, .service_factor_used, .k_amb_used);

// *** tb/thermal_overload_stage_bench.sv ***
// random and corner stimulus bench for the thermal overload output stage
`timescale 1ns/1ps
module thermal_overload_stage_bench;
  import thermal_overload_pkg::*;
  localparam int STEP = 4;
  logic hclk, hresetn, ce, hsel, hwrite, cycle_tick, blk_req, block_in, hreadyout, hresp;
  logic alarm1, alarm2, inhibit, trip, start, blocked, sf_fault, amb_fault, test_mode, ok;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, load_class;
  logic [2:0] hsize, condition;
  logic [3:0] lag, en;
  logic [TH_W-1:0] theta, lvl [NLVL];
  logic [CUR_W-1:0] i_meas, i_pickup, cur;
  logic [K_W-1:0] k_amb_calc, service_factor_used, k_amb_used;
  logic [TH_W-1:0] th_c [9] = '{11'h18F, 11'h190, 11'h257, 11'h258, 11'h31F, 11'h320,
                                11'h3E7, 11'h3E8, 11'h000};
  logic [CUR_W-1:0] cur_c [6] = '{16'h0009, 16'h000A, 16'h044C, 16'h044D, 16'h07D0, 16'h07D1};
  logic [K_W-1:0] sf_c [5] = '{10'h063, 10'h064, 10'h1F4, 10'h1F5, 10'h0C8};
  int miscompares, checks_done, cycles, n, d;

  thermal_overload_stage #(.STEP_CYC(STEP)) dut_u (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cycle_tick, .theta, .i_meas,
    .i_pickup, .k_amb_calc, .block_in, .alarm1, .alarm2, .inhibit, .trip, .start,
    .blocked, .condition, .load_class, .sf_fault, .amb_fault, .service_factor_used,
    .k_amb_used, .test_mode);
  block_source blk_u (.hclk, .hresetn, .blk_req, .lag, .block_in);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic tick(input logic [TH_W-1:0] t);
    @(posedge hclk);
    theta <= t;
    cycle_tick <= 1'b1;
    @(posedge hclk);
    cycle_tick <= 1'b0;
    #1;
  endtask

  task automatic set_lvl(input int k, input logic [TH_W-1:0] v);
    lvl[k] = v;
    bus(1'b1, A_SET0 + 8'(4 * k), 32'(v));
  endtask

  function automatic logic [8:0] expect_out(input logic [TH_W-1:0] t, input logic [3:0] e,
                                           input logic b);
    logic [3:0] hit;
    logic [2:0] c;
    for (int k = 0; k < NLVL; k++) hit[k] = e[k] && t >= lvl[k];
    c = (b && hit[3]) ? COND_BLOCKED : hit[3] ? COND_TRIP : hit[2] ? COND_INHIBIT :
        hit[1] ? COND_ALARM2 : hit[0] ? COND_ALARM1 : COND_NORMAL;
    return {c, b && hit[3], hit[3] && !b, hit[3] && !b, hit[2:0]};
  endfunction

  function automatic logic [1:0] exp_load(input logic [CUR_W-1:0] i);
    return i < LIGHT_LIM ? LOAD_LIGHT : i > HIGH_LIM ? LOAD_HIGH :
           i > i_pickup ? LOAD_OVER : LOAD_NORMAL;
  endfunction

  // trip delay is left at zero here, so three cycles cover start and trip
  task automatic eval(input logic [TH_W-1:0] t, input logic [3:0] e, input logic b);
    tick(t);
    repeat (3) @(posedge hclk);
    #1;
    chk(32'({condition, blocked, start, trip, inhibit, alarm2, alarm1}), 32'(expect_out(t, e, b)));
  endtask

  initial begin
    {hresetn, hsel, hwrite, cycle_tick, blk_req} = '0;
    {haddr, hwdata, htrans, theta, i_meas, lag} = '0;
    ce = 1'b1;
    hsize = 3'h2;
    i_pickup = 16'h044C;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    lvl = '{LVL_A1_RST, LVL_A2_RST, LVL_INH_RST, LVL_TRIP_RST};
    void'($urandom(69));
    k_amb_calc = 10'($urandom_range(400, 50));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, A_SET0 + 8'(4 * k), 32'h0);
      chk(rd, k < 4 ? 32'(lvl[k]) : 32'h0);
    end
    bus(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, A_SF, 32'h0);
    chk(rd, 32'(K_ONE));
    bus(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    eval(11'h3E8, 4'h0, 1'b0);
    bus(1'b1, A_CTRL, 32'hF);
    set_lvl(1, 11'h258);
    foreach (th_c[k]) eval(th_c[k], 4'hF, 1'b0);
    repeat (24) begin
      en = 4'($urandom_range(15));
      bus(1'b1, A_CTRL, 32'(en));
      eval(11'($urandom_range(1500)), en, 1'b0);
    end
    bus(1'b1, A_CTRL, 32'hF);
    for (int k = 0; k < 2; k++) begin
      d = k ? int'($urandom_range(5, 1)) : 0;
      eval(11'h000, 4'hF, 1'b0);
      bus(1'b1, A_SET0 + A_DLY_OFS, 32'(d));
      tick(11'h3E8);
      n = 0;
      while (trip !== 1'b1 && n < 100) begin
        @(posedge hclk);
        #1;
        n++;
      end
      chk(32'(n), 32'(d * STEP + 1));
    end
    bus(1'b1, A_SET0 + A_DLY_OFS, 32'h0);
    eval(11'h3E8, 4'hF, 1'b0);
    @(posedge hclk);
    blk_req <= 1'b1;
    lag <= 4'($urandom_range(6));
    repeat (12) @(posedge hclk);
    #1;
    chk(32'(start), 32'h1);
    eval(11'h3E8, 4'hF, 1'b1);
    @(posedge hclk);
    blk_req <= 1'b0;
    repeat (12) @(posedge hclk);
    eval(11'h3E8, 4'hF, 1'b0);
    for (int m = 0; m < 5; m++) begin
      bus(1'b1, A_CTRL, 32'hF | 32'(m << CTRL_MODE_LSB));
      eval(11'h3E8, (m == 4) ? 4'h0 : 4'hF, m == 1 || m == 3);
      chk(32'(test_mode), 32'(m == 2 || m == 3));
    end
    // switch the stage back on from off with the second set selected; its trip level differs
    bus(1'b1, A_SET1 + 8'h0C, 32'h1F4);
    bus(1'b1, A_CTRL, 32'h10F);
    lvl = '{LVL_A1_RST, LVL_A2_RST, LVL_INH_RST, 11'h1F4};
    for (int k = 0; k < 12; k++) begin
      cur = k < 6 ? cur_c[k] : 16'($urandom_range(3000));
      @(posedge hclk);
      i_meas <= cur;
      eval(11'h258, 4'hF, 1'b0);
      chk(32'(load_class), 32'(exp_load(cur)));
    end
    foreach (sf_c[k]) begin
      bus(1'b1, A_SF, 32'(sf_c[k]));
      bus(1'b1, A_AMB_T, (k % 2) ? 32'h002D_002D : 32'h002D_0000);
      eval(11'h258, 4'hF, 1'b0);
      ok = sf_c[k] >= SF_MIN && sf_c[k] <= SF_MAX;
      chk(32'({sf_fault, service_factor_used}), 32'({!ok, ok ? sf_c[k] : K_ONE}));
      chk(32'({amb_fault, k_amb_used}), 32'({k % 2 == 1, (k % 2) ? K_ONE : k_amb_calc}));
    end
    // a tick with capacity gone must be ignored while frozen, and the bus stalls
    @(posedge hclk);
    ce <= 1'b0;
    theta <= 11'h000;
    cycle_tick <= 1'b1;
    repeat (4) @(posedge hclk);
    #1;
    chk(32'({hreadyout, start, trip, alarm1}), 32'h7);
    @(posedge hclk);
    ce <= 1'b1;
    cycle_tick <= 1'b0;
    test_done();
  end
endmodule
